//--- include/scp_pkg.sv
`default_nettype none
package scp_pkg;
  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEN    = 8'h04;
  localparam logic [7:0] ADDR_DIV    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Control fields
  localparam int CTRL_PROGRAM_BIT = 0;
  localparam int CTRL_FAST_BIT    = 1;
  localparam int CTRL_EARLY_BIT   = 2;
  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB  = 4;
  localparam int STAT_DONE_BIT  = 8;
  localparam int STAT_INIT_BIT  = 9;
  localparam int STAT_OWN_BIT   = 10;
  // Reset values
  localparam logic [31:0] LEN_RESET  = 32'h0000_0400;
  localparam logic [15:0] DIV_RESET  = 16'h0020;
  localparam logic        FAST_RESET = 1'b0;
  localparam logic        EARLY_RESET = 1'b0;
  // Mode pin codes, most significant first
  localparam logic [2:0] MODE_SLAVE  = 3'h7;
  localparam logic [2:0] MODE_MASTER = 3'h0;
  // Stream framing
  localparam logic [31:0] PREAMBLE_BITS   = 32'h0000_0028;
  localparam logic [31:0] FAST_START_BITS = 32'h0000_0010;
  localparam int          FAST_SHIFT      = 3;
  // Timing
  localparam int CORE_PERIOD_NS = 8;
  localparam int INIT_CLEAR_NS  = 1000;
  localparam int INIT_CLEAR_CYC = (INIT_CLEAR_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DONE_LAG_NS    = 400;
  localparam int DONE_LAG_CYC   = (DONE_LAG_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_CLEAR, ST_WAIT_INIT, ST_LOAD, ST_FINISH, ST_DONE, ST_BAD_MODE
  } scp_state_t;
endpackage
`default_nettype wire

//--- hw/scp_sync.sv
`default_nettype none
module scp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- hw/scp_clkgen.sv
`default_nettype none
module scp_clkgen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] halfPeriod,
  // Generated clock and its edges
  output logic             cfgClk,
  output logic             risePulse,
  output logic             fallPulse
);
  logic [15:0] cnt_q;
  logic        tick;

  // Edge falls due when a half period has elapsed
  assign tick      = run && (cnt_q >= halfPeriod - 16'h0001);
  assign risePulse = tick && !cfgClk;
  assign fallPulse = tick && cfgClk;

  // Half-period counter; idle clock parks low so the memory sees no stray edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 16'h0000;
      cfgClk <= 1'b0;
    end else if (!run) begin
      cnt_q  <= 16'h0000;
      cfgClk <= 1'b0;
    end else if (tick) begin
      cnt_q  <= 16'h0000;
      cfgClk <= !cfgClk;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- hw/scp_top.sv
`default_nettype none
module scp_top
  import scp_pkg::*;
(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Config clock pin: input in slave mode, driven in master mode
  input  wire logic        cfgClkIn,
  output logic             cfgClkOut,
  output logic             cfgClkOe,
  // Serial data
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  // Mode select straps
  input  wire logic        modeSelect2,
  input  wire logic        modeSelect1,
  input  wire logic        modeSelect0,
  // Open-drain init line
  input  wire logic        initIn,
  output logic             initOut,
  output logic             initOe,
  // Configuration status pins
  output logic             lowDuringConfig,
  output logic             configDone
);
  scp_state_t  state_q;
  logic [31:0] len_q;
  logic [15:0] div_q;
  logic        fast_q;
  logic        early_q;
  logic [2:0]  mode_q;
  logic [15:0] lagCnt_q;
  logic        programPulse;
  logic [2:0]  modePins;
  logic [2:0]  modeSync;
  logic        initSync;
  logic        dinSync;
  logic        isMaster;
  logic        isSlave;
  logic        loading;
  logic        ownLoaded;
  logic [32:0] ownEnd;

  // Master-side pipeline
  logic [31:0] mCnt_q;
  logic        mStage1_q;
  logic        mStage2_q;
  logic        mDout_q;
  logic [31:0] mOwn_q;
  logic        mRun;
  logic        mRise;
  logic        mFall;
  logic        mClk;
  logic [15:0] halfPeriod;
  logic [15:0] fastHalf;

  // Slave-side (config clock domain, except armCore_q and sDoneCore on core_clk)
  logic        armCore_q;
  logic        armLink;
  logic [31:0] sCnt_q;
  logic        sFwd_q;
  logic        sDout_q;
  logic [31:0] sOwn_q;
  logic        sDone_q;
  logic        sDoneCore;
  logic [32:0] sEnd_q;

  // Pins, strap inputs and the slave done flag crossing into the core domain
  assign modePins = {modeSelect2, modeSelect1, modeSelect0};

  scp_sync #(.W(3)) modeSyncInst (
    .clk     (core_clk),
    .rst     (rst),
    .asyncIn (modePins),
    .syncOut (modeSync)
  );

  scp_sync #(.W(1)) initSyncInst (
    .clk     (core_clk),
    .rst     (rst),
    .asyncIn (initIn),
    .syncOut (initSync)
  );

  scp_sync #(.W(1)) dinSyncInst (
    .clk     (core_clk),
    .rst     (rst),
    .asyncIn (serialDataIn),
    .syncOut (dinSync)
  );

  scp_sync #(.W(1)) sDoneSyncInst (
    .clk     (core_clk),
    .rst     (rst),
    .asyncIn (sDone_q),
    .syncOut (sDoneCore)
  );

  // Decoded modes and framing limit
  assign isMaster  = (mode_q == MODE_MASTER);
  assign isSlave   = (mode_q == MODE_SLAVE);
  assign loading   = (state_q == ST_LOAD) || (state_q == ST_FINISH);
  assign ownEnd    = {1'b0, PREAMBLE_BITS} + {1'b0, len_q};
  assign ownLoaded = isMaster ? ({1'b0, mCnt_q} >= ownEnd) : sDoneCore;

  // APB: access phase always completes at once; reads decode in the setup cycle, writes in the access cycle
  assign pready       = psel && penable;
  assign programPulse = psel && penable && pwrite && (paddr == ADDR_CTRL)
                        && pwdata[CTRL_PROGRAM_BIT];

  // Read data and error captured in setup so the access phase answers from flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      unique case (paddr)
        ADDR_CTRL: begin
          if (!pwrite) begin
            prdata[CTRL_FAST_BIT]  <= fast_q;
            prdata[CTRL_EARLY_BIT] <= early_q;
          end
        end
        ADDR_LEN: begin
          if (!pwrite) prdata <= len_q;
        end
        ADDR_DIV: begin
          if (!pwrite) prdata[15:0] <= div_q;
        end
        ADDR_STATUS: begin
          if (!pwrite) begin
            prdata[STAT_STATE_LSB +: 3] <= state_q;
            prdata[STAT_MODE_LSB +: 3]  <= mode_q;
            prdata[STAT_DONE_BIT]       <= configDone;
            prdata[STAT_INIT_BIT]       <= initSync;
            prdata[STAT_OWN_BIT]        <= ownLoaded;
          end
        end
        default: pslverr <= 1'b1;
      endcase
    end
  end

  // Writable settings; length and divider frozen while a load is running
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      len_q   <= LEN_RESET;
      div_q   <= DIV_RESET;
      fast_q  <= FAST_RESET;
      early_q <= EARLY_RESET;
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        fast_q  <= pwdata[CTRL_FAST_BIT];
        early_q <= pwdata[CTRL_EARLY_BIT];
      end
      if (paddr == ADDR_LEN && !loading) len_q <= pwdata;
      if (paddr == ADDR_DIV && !loading) div_q <= pwdata[15:0];
    end
  end

  // Configuration sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q  <= ST_CLEAR;
      mode_q   <= MODE_SLAVE;
      lagCnt_q <= 16'h0000;
    end else if (programPulse) begin
      state_q  <= ST_CLEAR;
      lagCnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_CLEAR: begin
          // Hold init low long enough for every chained device to see it
          if (lagCnt_q == 16'(INIT_CLEAR_CYC - 1)) begin
            lagCnt_q <= 16'h0000;
            state_q  <= ST_WAIT_INIT;
          end else begin
            lagCnt_q <= lagCnt_q + 16'h0001;
          end
        end
        ST_WAIT_INIT: begin
          // Wired init only rises once all devices let go; straps taken here
          if (initSync) begin
            mode_q <= modeSync;
            if (modeSync == MODE_SLAVE || modeSync == MODE_MASTER) begin
              state_q <= ST_LOAD;
            end else begin
              state_q <= ST_BAD_MODE;
            end
          end
        end
        ST_LOAD: begin
          if (ownLoaded) state_q <= ST_FINISH;
        end
        ST_FINISH: begin
          if (lagCnt_q == 16'(DONE_LAG_CYC - 1)) begin
            lagCnt_q <= 16'h0000;
            state_q  <= ST_DONE;
          end else begin
            lagCnt_q <= lagCnt_q + 16'h0001;
          end
        end
        ST_DONE: state_q <= ST_DONE;
        ST_BAD_MODE: state_q <= ST_BAD_MODE;
      endcase
    end
  end

  // Open-drain init: only ever pulls low, never drives high
  assign initOut = 1'b0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      initOe <= 1'b1;
    end else begin
      initOe <= (state_q == ST_CLEAR) || (state_q == ST_BAD_MODE);
    end
  end

  // Completion and low-during-config outputs for the memory enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      configDone      <= 1'b0;
      lowDuringConfig <= 1'b0;
    end else begin
      // Early completion raises configDone as soon as our bits are in; the memory enable waits for ST_DONE
      configDone      <= (state_q == ST_DONE)
                         || (early_q && state_q == ST_FINISH);
      lowDuringConfig <= (state_q == ST_DONE);
    end
  end

  // Master mode: generated clock, sped up once past the first few bits
  assign fastHalf   = (div_q >> FAST_SHIFT) == 16'h0000 ? 16'h0001 : (div_q >> FAST_SHIFT);
  assign halfPeriod = (fast_q && mCnt_q >= FAST_START_BITS) ? fastHalf
                      : ((div_q == 16'h0000) ? 16'h0001 : div_q);
  assign mRun       = isMaster && loading;

  scp_clkgen clkgenInst (
    .clk        (core_clk),
    .rst        (rst),
    .run        (mRun),
    .halfPeriod (halfPeriod),
    .cfgClk     (mClk),
    .risePulse  (mRise),
    .fallPulse  (mFall)
  );

  // Pin is driven only in master mode; slave mode leaves it to upstream
  assign cfgClkOut = mClk;
  assign cfgClkOe  = isMaster && (state_q != ST_WAIT_INIT) && (state_q != ST_CLEAR);

  // Master capture: each rise takes the bit the previous rise advanced to
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mCnt_q    <= 32'h0000_0000;
      mStage1_q <= 1'b1;
      mStage2_q <= 1'b1;
      mOwn_q    <= 32'h0000_0000;
    end else if (state_q == ST_CLEAR) begin
      mCnt_q    <= 32'h0000_0000;
      mStage1_q <= 1'b1;
      mStage2_q <= 1'b1;
    end else if (mRise) begin
      mCnt_q    <= mCnt_q + 32'h0000_0001;
      mStage2_q <= mStage1_q;
      if (mCnt_q < PREAMBLE_BITS || {1'b0, mCnt_q} >= ownEnd) begin
        mStage1_q <= dinSync;
      end else begin
        mStage1_q <= 1'b1;
        mOwn_q    <= {mOwn_q[30:0], dinSync};
      end
    end
  end

  // Two-stage pipe plus falling edge gives the 1.5 period forward delay
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mDout_q <= 1'b1;
    end else if (mFall) begin
      mDout_q <= mStage2_q;
    end
  end

  // Arm level for the link side; length is quasi-static while armed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armCore_q <= 1'b0;
    end else begin
      armCore_q <= isSlave && loading;
    end
  end

  scp_sync #(.W(1)) armSyncInst (
    .clk     (cfgClkIn),
    .rst     (rst),
    .asyncIn (armCore_q),
    .syncOut (armLink)
  );

  // Slave mode: data in is synchronous to the upstream clock, sampled on rise
  always_ff @(posedge cfgClkIn or posedge rst) begin
    if (rst) begin
      sCnt_q  <= 32'h0000_0000;
      sFwd_q  <= 1'b1;
      sOwn_q  <= 32'h0000_0000;
      sDone_q <= 1'b0;
      sEnd_q  <= 33'h0_0000_0000;
    end else if (!armLink) begin
      sCnt_q  <= 32'h0000_0000;
      sFwd_q  <= 1'b1;
      sDone_q <= 1'b0;
      // Local copy of the frame end; core length may move again once disarmed
      sEnd_q  <= ownEnd;
    end else begin
      sCnt_q <= sCnt_q + 32'h0000_0001;
      if (sCnt_q < PREAMBLE_BITS || {1'b0, sCnt_q} >= sEnd_q) begin
        sFwd_q <= serialDataIn;
      end else begin
        sFwd_q <= 1'b1;
        sOwn_q <= {sOwn_q[30:0], serialDataIn};
      end
      if ({1'b0, sCnt_q} + 33'h0_0000_0001 >= sEnd_q) sDone_q <= 1'b1;
    end
  end

  // Forwarded bit leaves on the falling edge, half a period after sampling
  always_ff @(negedge cfgClkIn or posedge rst) begin
    if (rst) begin
      sDout_q <= 1'b1;
    end else begin
      sDout_q <= sFwd_q;
    end
  end

  // Chain output follows the active mode; idles high otherwise
  assign serialDataOut = isMaster ? mDout_q : (isSlave ? sDout_q : 1'b1);
endmodule
`default_nettype wire

//--- testbench/scp_top_assertions.sv
`default_nettype none
module scp_checker
  import scp_pkg::*;
(
  // Core clock, reset and bus
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // Configuration pins
  input wire logic       cfgClkIn,
  input wire logic       cfgClkOut,
  input wire logic       cfgClkOe,
  input wire logic       serialDataOut,
  input wire logic       modeSelect2,
  input wire logic       modeSelect1,
  input wire logic       modeSelect0,
  input wire logic       initOut,
  input wire logic       initOe,
  input wire logic       lowDuringConfig,
  input wire logic       configDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic riseVal_q;
  // Output seen at each link rise; it may move only at the fall
  always_ff @(posedge cfgClkIn or posedge rst) begin
    if (rst) riseVal_q <= 1'h1;
    else riseVal_q <= serialDataOut;
  end
  // Slave straps held for a few cycles
  sequence s_slave;
    ({modeSelect2, modeSelect1, modeSelect0} == MODE_SLAVE) [*4];
  endsequence
  property p_unmapped;
    @(posedge core_clk) disable iff (rst) psel && penable && paddr > ADDR_STATUS |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  property p_lowCfgSticky;
    @(posedge core_clk) disable iff (rst) lowDuringConfig |=> lowDuringConfig;
  endproperty
  a_lowCfgSticky: assert property (p_lowCfgSticky) else $error("low-during-config dropped");
  property p_lowCfgDone;
    @(posedge core_clk) disable iff (rst) lowDuringConfig |-> configDone;
  endproperty
  a_lowCfgDone: assert property (p_lowCfgDone) else $error("low-during-config before done");
  // Init only ever pulls low, and lets go once our load is complete
  property p_initOd;
    @(posedge core_clk) disable iff (rst) !initOut && !(configDone && initOe);
  endproperty
  a_initOd: assert property (p_initOd) else $error("init driven high");
  property p_clkOnlyOe;
    @(posedge core_clk) disable iff (rst) cfgClkOut |-> cfgClkOe;
  endproperty
  a_clkOnlyOe: assert property (p_clkOnlyOe) else $error("clock high undriven");
  property p_slaveNoDrive;
    @(posedge core_clk) disable iff (rst) s_slave |-> !cfgClkOe;
  endproperty
  a_slaveNoDrive: assert property (p_slaveNoDrive) else $error("slave drives clock");
  property p_masterFall;
    @(posedge core_clk) disable iff (rst) cfgClkOe && $changed(serialDataOut) |-> !cfgClkOut;
  endproperty
  a_masterFall: assert property (p_masterFall) else $error("out moved on high");
  property p_slaveRise;
    @(negedge cfgClkIn) disable iff (rst)
      {modeSelect2, modeSelect1, modeSelect0} == MODE_SLAVE |-> serialDataOut == riseVal_q;
  endproperty
  a_slaveRise: assert property (p_slaveRise) else $error("out moved on rise");
endmodule
bind scp_top scp_checker i_chk (.core_clk, .rst, .psel, .penable, .paddr, .pslverr, .cfgClkIn,
  .cfgClkOut, .cfgClkOe, .serialDataOut, .modeSelect2, .modeSelect1, .modeSelect0, .initOut,
  .initOe, .lowDuringConfig, .configDone);
`default_nettype wire

//--- testbench/scp_mem_model.sv
`default_nettype none
module scp_mem_model (
  // Clock from the device, reset, active-low enable
  input  wire logic         cfgClk,
  input  wire logic         rst,
  input  wire logic         enableN,
  // Stored stream and serial output
  input  wire logic [127:0] image,
  output logic              dataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] addr_q;
  // Each rising clock while enabled steps to the next bit
  always_ff @(posedge cfgClk or posedge rst) begin
    if (rst) addr_q <= 7'h0;
    else if (!enableN) addr_q <= addr_q + 7'h1;
  end
  // Bit is ready long before the next rise; disabled, the pin shows garbage
  assign dataOut = enableN ? ~image[addr_q] : image[addr_q];
endmodule
`default_nettype wire

//--- testbench/serial_config_port_tb.sv
`default_nettype none
module serial_config_port_tb
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LEN = 24;
  localparam int NB  = 68;
  localparam int DIV = 16;
  logic         core_clk, rst, psel, penable, pwrite, pready, pslverr, er, mst;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         cfgClkIn, cfgClkOut, cfgClkOe, serialDataIn, serialDataOut, slvData;
  logic         initIn, initOut, initOe, lowDuringConfig, configDone, memData;
  logic [2:0]   mode;
  logic [127:0] img;
  int           miscompares, testsRun, cyc, mr, riseCyc;
  // Wired init with pull-up; data source picked by mode
  assign initIn = !initOe;
  assign serialDataIn = mst ? memData : slvData;
  scp_top i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .cfgClkIn, .cfgClkOut, .cfgClkOe, .serialDataIn, .serialDataOut,
    .modeSelect2(mode[2]), .modeSelect1(mode[1]), .modeSelect0(mode[0]), .initIn, .initOut,
    .initOe, .lowDuringConfig, .configDone);
  // Memory enabled while low-during-config is low
  scp_mem_model i_mem (.cfgClk(cfgClkOut), .rst, .enableN(lowDuringConfig), .image(img),
    .dataOut(memData));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Preamble and overflow bits pass through, own bits show high
  function automatic logic expBit(input int i);
    return (i < PREAMBLE_BITS || i >= PREAMBLE_BITS + LEN) ? img[i] : 1'h1;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic start(input logic [2:0] m);
    rst <= 1'h1;
    mode <= m;
    mst <= (m == MODE_MASTER);
    mr = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
  endtask
  task automatic cfg(input logic [31:0] ctl);
    apb(1'h1, ADDR_LEN, LEN);
    apb(1'h1, ADDR_DIV, DIV);
    apb(1'h1, ADDR_CTRL, ctl);
  endtask
  // Watchdog and cycle count
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end
  // Master link: forwarded bit and clock period at chosen rises
  always @(posedge cfgClkOut) begin
    if (mst && mr >= 2) chk("masterOut", serialDataOut, expBit(mr - 2));
    if (mst && mr == 8) chk("slowPeriod", cyc - riseCyc, 2 * DIV);
    if (mst && mr == 40) chk("fastPeriod", cyc - riseCyc, 2 * (DIV >> FAST_SHIFT));
    riseCyc = cyc;
    mr++;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, cfgClkIn, mst} = '0;
    rst = 1'h1;
    slvData = 1'h1;
    mode = MODE_SLAVE;
    {miscompares, testsRun, cyc, mr, riseCyc} = '0;
    void'($urandom(32'h50f3));
    img = {$urandom(), $urandom(), $urandom(), $urandom()};
    img[64:40] = 25'h0; // Own bits low so the high fill shows
    // Slave run with reset values and an unmapped access
    start(MODE_SLAVE);
    chk("initLow", initOe, 32'h1);
    chk("clkOe", cfgClkOe, 32'h0);
    apb(1'h0, ADDR_LEN, 32'h0);
    chk("lenReset", rd, LEN_RESET);
    apb(1'h0, ADDR_DIV, 32'h0);
    chk("divReset", rd, {16'h0, DIV_RESET});
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    cfg(32'h0);
    while (initIn !== 1'h1) @(posedge core_clk);
    do apb(1'h0, ADDR_STATUS, 32'h0); while (rd[2:0] !== ST_LOAD);
    chk("slaveMode", rd[6:4], MODE_SLAVE);
    chk("slaveClkOe", cfgClkOe, 32'h0);
    apb(1'h1, ADDR_LEN, 32'h5);
    apb(1'h0, ADDR_LEN, 32'h0);
    chk("lenLocked", rd, LEN);
    #3;
    // Two arming edges, then the stream; data moves while the clock is low
    for (int k = 0; k < NB + 3; k++) begin
      slvData <= (k < 2) ? 1'h1 : img[k - 2];
      #23;
      if (k > 2) chk("slaveOut", serialDataOut, expBit(k - 3));
      #1 cfgClkIn = 1'h1;
      #24 cfgClkIn = 1'h0;
    end
    repeat (80) @(posedge core_clk);
    chk("slaveDone", {lowDuringConfig, configDone}, 32'h3);
    // Master run with fast rate and early completion
    start(MODE_MASTER);
    cfg(32'h6);
    while (configDone !== 1'h1) @(posedge core_clk);
    chk("earlyLowCfg", lowDuringConfig, 32'h0);
    chk("masterClkOe", cfgClkOe, 32'h1);
    repeat (80) @(posedge core_clk);
    chk("masterLowCfg", lowDuringConfig, 32'h1);
    chk("masterBits", mr > PREAMBLE_BITS + LEN, 32'h1);
    // Any other strap code is refused
    start(3'h1 + 3'($urandom_range(5)));
    repeat (300) @(posedge core_clk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk("badMode", rd[2:0], ST_BAD_MODE);
    chk("badInit", initOe, 32'h1);
    test_done;
  end
endmodule
`default_nettype wire
